// File: verilog/prio_select_pkg.sv
package prio_select_pkg;

    // Register word offsets (byte addresses on the bus)
    localparam logic [3:0] SELECT_ONE_OFFSET = 4'h0;
    localparam logic [3:0] SELECT_TWO_OFFSET = 4'h4;
    localparam logic [3:0] CONTROL_OFFSET = 4'h8;
    localparam int ADDR_WIDTH = 4;

    // Implemented-bit masks and reset values
    localparam logic [7:0] SELECT_ONE_MASK = 8'h7b;
    localparam logic [7:0] SELECT_TWO_MASK = 8'hce;
    localparam logic [7:0] SELECT_ONE_RESET = 8'h7b;
    localparam logic [7:0] SELECT_TWO_RESET = 8'hce;
    localparam logic [7:0] CONTROL_MASK = 8'h01;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // Field positions, first select register
    localparam int CONVERTER_BIT = 6;
    localparam int SERIAL_RX_BIT = 5;
    localparam int SERIAL_TX_BIT = 4;
    localparam int SYNC_SERIAL_BIT = 3;
    localparam int SECOND_TIMER_BIT = 1;
    localparam int FIRST_TIMER_BIT = 0;
    // Field positions, second select register
    localparam int OSC_FAIL_BIT = 7;
    localparam int COMPARATOR_BIT = 6;
    localparam int BUS_COLLISION_BIT = 3;
    localparam int LOW_VOLTAGE_BIT = 2;
    localparam int THIRD_TIMER_BIT = 1;
    // Enable bit in control register
    localparam int ENABLE_BIT = 0;

    // Per-source priority levels, 1 = high vector
    typedef struct packed {
        logic converter_prio;
        logic serial_rx_prio;
        logic serial_tx_prio;
        logic sync_serial_prio;
        logic second_timer_match_prio;
        logic first_timer_overflow_prio;
        logic osc_fail_prio;
        logic comparator_prio;
        logic bus_collision_prio;
        logic low_voltage_prio;
        logic third_timer_overflow_prio;
    } prio_levels_t;

endpackage : prio_select_pkg

// File: verilog/peripheral_irq_priority_select.sv
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module peripheral_irq_priority_select (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Classic Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [prio_select_pkg::ADDR_WIDTH-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Effective priority per source, 1 = high vector
    output prio_select_pkg::prio_levels_t prio_levels_o,
    output logic global_priority_enable_o
);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] select_one_ff, nxt_select_one;
    logic [7:0] select_two_ff, nxt_select_two;
    logic [7:0] control_ff, nxt_control;
    logic ack_ff, nxt_ack;
    logic [31:0] rdata_ff, nxt_rdata;
    prio_select_pkg::prio_levels_t levels_ff, nxt_levels;
    logic req;
    logic wr_lane0;

    // Request seen only while no ack is out, so each access acks once
    assign req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr_lane0 = req && wb_we_i && wb_sel_i[0];

    ////////////////////////////////////////////////////////////////////////
    // Register writes; masking keeps unimplemented bits at zero
    always_comb begin
        nxt_select_one = select_one_ff;
        nxt_select_two = select_two_ff;
        nxt_control = control_ff;
        if (wr_lane0) begin
            unique case (wb_adr_i)
                prio_select_pkg::SELECT_ONE_OFFSET: begin
                    nxt_select_one = wb_dat_i[7:0] & prio_select_pkg::SELECT_ONE_MASK;
                end
                prio_select_pkg::SELECT_TWO_OFFSET: begin
                    nxt_select_two = wb_dat_i[7:0] & prio_select_pkg::SELECT_TWO_MASK;
                end
                prio_select_pkg::CONTROL_OFFSET: begin
                    nxt_control = wb_dat_i[7:0] & prio_select_pkg::CONTROL_MASK;
                end
                default: begin
                    nxt_control = control_ff;
                end
            endcase
        end
    end

    // Bus answer: one cycle after request, unmapped reads give zero
    always_comb begin
        nxt_ack = req;
        nxt_rdata = 32'h0000_0000;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                prio_select_pkg::SELECT_ONE_OFFSET: nxt_rdata[7:0] = select_one_ff;
                prio_select_pkg::SELECT_TWO_OFFSET: nxt_rdata[7:0] = select_two_ff;
                prio_select_pkg::CONTROL_OFFSET: nxt_rdata[7:0] = control_ff;
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Effective levels; with enable clear every source drops to one level
    always_comb begin
        logic en;
        en = control_ff[prio_select_pkg::ENABLE_BIT];
        nxt_levels.converter_prio = en & select_one_ff[prio_select_pkg::CONVERTER_BIT];
        nxt_levels.serial_rx_prio = en & select_one_ff[prio_select_pkg::SERIAL_RX_BIT];
        nxt_levels.serial_tx_prio = en & select_one_ff[prio_select_pkg::SERIAL_TX_BIT];
        nxt_levels.sync_serial_prio = en & select_one_ff[prio_select_pkg::SYNC_SERIAL_BIT];
        nxt_levels.second_timer_match_prio =
            en & select_one_ff[prio_select_pkg::SECOND_TIMER_BIT];
        nxt_levels.first_timer_overflow_prio =
            en & select_one_ff[prio_select_pkg::FIRST_TIMER_BIT];
        nxt_levels.osc_fail_prio = en & select_two_ff[prio_select_pkg::OSC_FAIL_BIT];
        nxt_levels.comparator_prio = en & select_two_ff[prio_select_pkg::COMPARATOR_BIT];
        nxt_levels.bus_collision_prio =
            en & select_two_ff[prio_select_pkg::BUS_COLLISION_BIT];
        nxt_levels.low_voltage_prio = en & select_two_ff[prio_select_pkg::LOW_VOLTAGE_BIT];
        nxt_levels.third_timer_overflow_prio =
            en & select_two_ff[prio_select_pkg::THIRD_TIMER_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers; single level when disabled means all low vector
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            select_one_ff <= prio_select_pkg::SELECT_ONE_RESET;
            select_two_ff <= prio_select_pkg::SELECT_TWO_RESET;
            control_ff <= prio_select_pkg::CONTROL_RESET;
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            levels_ff <= '0;
        end else begin
            select_one_ff <= nxt_select_one;
            select_two_ff <= nxt_select_two;
            control_ff <= nxt_control;
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
            levels_ff <= nxt_levels;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;
    assign prio_levels_o = levels_ff;
    assign global_priority_enable_o = control_ff[prio_select_pkg::ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_write_one;
        wr_lane0 && wb_adr_i == prio_select_pkg::SELECT_ONE_OFFSET;
    endsequence

    a_rx_level: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 prio_levels_o.serial_rx_prio == ($past(select_one_ff[5]) & $past(control_ff[0])))
        else $error("serial rx level wrong");
    a_tx_level: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 prio_levels_o.serial_tx_prio == ($past(select_one_ff[4]) & $past(control_ff[0])))
        else $error("serial tx level wrong");
    a_sync_level: assert property (@(posedge clk_i) disable iff (rst_i)
        s_write_one ##1 control_ff[0] |=> prio_levels_o.sync_serial_prio == select_one_ff[3])
        else $error("sync serial level wrong");
    a_cmp_level: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 prio_levels_o.comparator_prio == ($past(select_two_ff[6]) & $past(control_ff[0])))
        else $error("comparator level wrong");
    a_bcl_level: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 prio_levels_o.bus_collision_prio == ($past(select_two_ff[3]) & $past(control_ff[0])))
        else $error("bus collision level wrong");
    a_lvd_level: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 prio_levels_o.low_voltage_prio == ($past(select_two_ff[2]) & $past(control_ff[0])))
        else $error("low voltage level wrong");
    a_third_timer_level: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 prio_levels_o.third_timer_overflow_prio ==
            ($past(select_two_ff[1]) & $past(control_ff[0])))
        else $error("third timer level wrong");
    a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (select_one_ff & 8'h84) == 8'h00 && (select_two_ff & 8'h31) == 8'h00)
        else $error("unimplemented bit set");
    a_other_level: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 prio_levels_o.osc_fail_prio == ($past(select_two_ff[7]) & $past(control_ff[0])))
        else $error("oscillator fail level wrong");
    a_reset_value: assert property (@(posedge clk_i)
        $past(rst_i) |-> select_one_ff == 8'h7b && select_two_ff == 8'hce)
        else $error("reset value wrong");
    a_disabled_low: assert property (@(posedge clk_i) disable iff (rst_i)
        !control_ff[0] [*2] |-> prio_levels_o == '0)
        else $error("levels active while disabled");

endmodule : peripheral_irq_priority_select

// File: dv/peripheral_irq_priority_select_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module peripheral_irq_priority_select_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    prio_select_pkg::prio_levels_t prio_levels_o;
    logic global_priority_enable_o;
    int errors = 0;
    int checks_done = 0;
    logic [31:0] rd;
    peripheral_irq_priority_select i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .prio_levels_o(prio_levels_o), .global_priority_enable_o(global_priority_enable_o));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, 25 ns period
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run, also reached from a hung bus wait
    task automatic conclude;
        $display("Checks done %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // One classic cycle; holds everything until ack is sampled high or 20 clocks pass
    task automatic access(input logic we, input logic [3:0] adr, input logic [7:0] d,
                          input logic [3:0] sel, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h00_0000, d};
        wb_sel_i <= sel;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 20) begin
            errors++;
            $display("ERROR bus ack never came");
            conclude();
        end
    endtask : access
    // Expected per-source levels; a clear enable flattens all to low
    function automatic prio_select_pkg::prio_levels_t exp_lv(logic [7:0] a, logic [7:0] b,
                                                             logic en);
        prio_select_pkg::prio_levels_t v;
        v = {a[6], a[5], a[4], a[3], a[1], a[0], b[7], b[6], b[3], b[2], b[1]};
        return en ? v : '0;
    endfunction : exp_lv
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] pat;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        access(1'b0, 4'h0, 8'h00, 4'hf, rd);
        `CHK("one reset", 32'h0000_007b, rd)
        access(1'b0, 4'h4, 8'h00, 4'hf, rd);
        `CHK("two reset", 32'h0000_00ce, rd)
        `CHK("levels off", exp_lv(8'h7b, 8'hce, 1'b0), prio_levels_o)
        access(1'b1, 4'h8, 8'h01, 4'hf, rd);
        access(1'b0, 4'hc, 8'h00, 4'hf, rd);
        `CHK("unmapped", 32'h0000_0000, rd)
        `CHK("levels reset", exp_lv(8'h7b, 8'hce, 1'b1), prio_levels_o)
        // Walk a single one, then a single zero, through every position of the first; the second gets the inverse
        for (int i = 0; i < 16; i++) begin
            pat = (i < 8) ? (8'h01 << i) : ~(8'h01 << (i - 8));
            access(1'b1, 4'h0, pat, 4'h1, rd);
            access(1'b1, 4'h4, ~pat, 4'h1, rd);
            access(1'b0, 4'h0, 8'h00, 4'hf, rd);
            `CHK("one walk", {24'h00_0000, pat & 8'h7b}, rd)
            access(1'b0, 4'h4, 8'h00, 4'hf, rd);
            `CHK("two walk", {24'h00_0000, ~pat & 8'hce}, rd)
            `CHK("levels", exp_lv(pat, ~pat, 1'b1), prio_levels_o)
        end
        // Write without the low byte lane must leave the register alone
        access(1'b1, 4'h0, 8'h00, 4'he, rd);
        access(1'b0, 4'h0, 8'h00, 4'hf, rd);
        `CHK("lane off", {24'h00_0000, ~8'h80 & 8'h7b}, rd)
        access(1'b1, 4'h8, 8'h00, 4'hf, rd);
        access(1'b0, 4'h8, 8'h00, 4'hf, rd);
        `CHK("enable off", 1'b0, global_priority_enable_o)
        `CHK("levels single", exp_lv(8'h7b, 8'hce, 1'b0), prio_levels_o)
        conclude();
    end
endmodule : peripheral_irq_priority_select_tb_top
